// >>> bench/decoder_monitor.sv
// checker on the top ports of the instruction format decoder
// assumes binding onto cpu_instruction_format_decoder, one clock domain
`timescale 1ns/1ps
module decoder_monitor (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   // watched outputs
   input decoder_pkg::quarter_t phase_o,
   input wire logic [1:0] cycles_o,
   input wire logic nop_cycle_o,
   input wire logic read_en_o,
   input wire logic [7:0] result_o,
   input wire logic write_file_o,
   input wire logic write_work_o,
   input wire logic [1:0] flag_nz_o,
   input wire logic flag_we_o,
   input wire logic pc_load_en_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // ====================
   // quarter order; first cycle after reset skipped, the phase copy lags one clock
   property p_phase_q1;
      $past(rstn_i) && clk_en_i && phase_o == decoder_pkg::Q1 |=> phase_o == decoder_pkg::Q2;
   endproperty
   a_phase_q1: assert property (p_phase_q1) else $error("quarter one not followed by two");
   property p_phase_q4;
      clk_en_i && phase_o == decoder_pkg::Q4 |=> phase_o == decoder_pkg::Q1;
   endproperty
   a_phase_q4: assert property (p_phase_q4) else $error("quarter four not followed by one");
   // ====================
   // pulses and write-back
   property p_read_pulse;
      read_en_o |=> !read_en_o;
   endproperty
   a_read_pulse: assert property (p_read_pulse) else $error("read enable longer than one clock");
   property p_one_dest;
      !(write_file_o && write_work_o);
   endproperty
   a_one_dest: assert property (p_one_dest) else $error("both destinations written");
   property p_flags;
      flag_we_o |-> flag_nz_o == {result_o[7], result_o == 8'h00};
   endproperty
   a_flags: assert property (p_flags) else $error("negative or zero flag wrong");
   property p_flag_pair;
      flag_we_o |-> write_file_o || write_work_o;
   endproperty
   a_flag_pair: assert property (p_flag_pair) else $error("flags written without result");
   // ====================
   // cycle accounting
   property p_nop_len;
      $rose(nop_cycle_o) |-> nop_cycle_o [*4] ##1 !nop_cycle_o;
   endproperty
   a_nop_len: assert property (p_nop_len) else $error("forced no-op not one cycle long");
   property p_pc_pulse;
      pc_load_en_o |=> !pc_load_en_o;
   endproperty
   a_pc_pulse: assert property (p_pc_pulse) else $error("counter load longer than one clock");
   property p_cycles;
      cycles_o == 2'h1 || cycles_o == 2'h2;
   endproperty
   a_cycles: assert property (p_cycles) else $error("cycle count outside one or two");
   // main scenarios reached
   c_flags: cover property (flag_we_o && write_file_o);
   c_pc: cover property (pc_load_en_o);
   c_nop: cover property ($rose(nop_cycle_o));
endmodule : decoder_monitor

bind cpu_instruction_format_decoder decoder_monitor mon (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .phase_o(phase_o),
   .cycles_o(cycles_o), .nop_cycle_o(nop_cycle_o), .read_en_o(read_en_o),
   .result_o(result_o), .write_file_o(write_file_o), .write_work_o(write_work_o),
   .flag_nz_o(flag_nz_o), .flag_we_o(flag_we_o), .pc_load_en_o(pc_load_en_o)
);

// >>> bench/tb_top.sv
// self-checking bench for the instruction format decoder
// assumes design sources and decoder_monitor compiled first
`timescale 1ns/1ps
module tb_top;
   localparam int LIMIT = 2000;
   // ====================
   // design connections
   logic clk, rstn, clk_en, carry, ext;
   logic [15:0] word;
   logic [20:0] pc, pcl;
   logic [7:0] wk, fo, res;
   logic [3:0] bank;
   decoder_pkg::decoded_t dec, got;
   decoder_pkg::quarter_t phase;
   logic [1:0] cycles, nz, got_cy, rnz;
   logic [11:0] raddr, ra;
   logic nopc, ren, wf, ww, fwe, pcle;
   logic s_rd, s_wf, s_ww, s_fl, s_pc, s_nop;
   logic [7:0] rv;
   logic [20:0] rpc;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;

   cpu_instruction_format_decoder #(.PC_WIDTH(21)) dut (
      .sys_clk_i(clk), .rstn_i(rstn), .clk_en_i(clk_en), .word_i(word), .pc_i(pc),
      .carry_i(carry), .working_register_i(wk), .file_operand_i(fo),
      .bank_select_register_i(bank), .extended_set_enable_bit_i(ext), .dec_o(dec),
      .phase_o(phase), .cycles_o(cycles), .nop_cycle_o(nopc), .read_addr_o(raddr),
      .read_en_o(ren), .result_o(res), .write_file_o(wf), .write_work_o(ww),
      .flag_nz_o(nz), .flag_we_o(fwe), .pc_load_o(pcl), .pc_load_en_o(pcle)
   );

   // ====================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end

   // ====================
   // shared helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic clr();
      {s_rd, s_wf, s_ww, s_fl, s_pc, s_nop} = 6'h00;
   endtask : clr
   // one instruction cycle; the Q4 pulses of this cycle land in its last sample
   task automatic step(input logic [15:0] w, input logic cap);
      word = w;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         @(negedge clk);
         if (cap && i == 1) begin
            got = dec;
            got_cy = cycles;
         end
         if (ren) begin
            s_rd = 1'b1;
            ra = raddr;
         end
         if (wf || ww) begin
            s_wf = s_wf | wf;
            s_ww = s_ww | ww;
            rv = res;
         end
         if (fwe) begin
            s_fl = 1'b1;
            rnz = nz;
         end
         if (pcle) begin
            s_pc = 1'b1;
            rpc = pcl;
         end
         if (nopc) s_nop = 1'b1;
      end
   endtask : step

   // ====================
   // scenarios
   task automatic and_case(input logic [15:0] w, input logic [3:0] b, input logic [7:0] x,
         input logic [7:0] y, input logic [11:0] a, input logic [7:0] r, input logic [1:0] f);
      bank = b;
      wk = x;
      fo = y;
      clr();
      step(w, 1'b1);
      step(16'hF000, 1'b0);
      chk(got.op_class, decoder_pkg::CLS_BYTE);
      chk(got.is_and_wf, 1'b1);
      chk({got.dest_is_file, got.bank_from_select}, w[9:8]);
      chk(got.file_addr[7:0], w[7:0]);
      chk({s_rd, ra}, {1'b1, a});
      chk({s_wf, s_ww}, {w[9], ~w[9]});
      chk(rv, r);
      chk({s_fl, rnz}, {1'b1, f});
   endtask : and_case
   task automatic t_and();
      and_case(16'h1485, 4'h3, 8'h17, 8'hC2, 12'hF85, 8'h02, 2'h0);
      and_case(16'h1740, 4'h3, 8'h80, 8'hFF, 12'h340, 8'h80, 2'h2);
      and_case(16'h1510, 4'hA, 8'h0F, 8'hF0, 12'hA10, 8'h00, 2'h1);
      and_case(16'h1610, 4'hA, 8'hFF, 8'h3C, 12'h010, 8'h3C, 2'h0);
      $display("test and_with_file done");
   endtask : t_and
   task automatic t_formats();
      step(16'h8B45, 1'b1);
      chk({got.op_class, got.bit_pos, got.bank_from_select}, {decoder_pkg::CLS_BIT, 4'hB});
      chk(got.file_addr[7:0], 8'h45);
      step(16'h0E7F, 1'b1);
      chk({got.op_class, got.literal}, {decoder_pkg::CLS_LITERAL, 8'h7F});
      clk_en = 1'b0;
      repeat (3) @(negedge clk);
      chk({phase, dec.literal}, {decoder_pkg::Q4, 8'h7F});
      clk_en = 1'b1;
      step(16'hE800, 1'b1);
      chk(got.op_class, decoder_pkg::CLS_ILLEGAL);
      ext = 1'b1;
      step(16'hE800, 1'b1);
      chk(got.op_class, decoder_pkg::CLS_EXTENDED);
      step(16'hF000, 1'b0);
      ext = 1'b0;
      clr();
      step(16'hF123, 1'b1);
      step(16'hF000, 1'b0);
      chk(got.op_class, decoder_pkg::CLS_NOP);
      chk({s_wf, s_ww, s_fl, s_pc}, 4'h0);
      $display("test word formats done");
   endtask : t_formats
   task automatic t_two();
      clr();
      step(16'hC123, 1'b1);
      step(16'hF456, 1'b0);
      chk({got.op_class, got.file_addr}, {decoder_pkg::CLS_MOVE_FF, 12'h123});
      chk({got.two_word, got_cy}, 3'h6);
      chk(raddr, 12'h456);
      clr();
      step(16'hEF34, 1'b1);
      step(16'hF567, 1'b0);
      step(16'hF000, 1'b0);
      chk(got.op_class, decoder_pkg::CLS_GOTO);
      chk({s_pc, rpc}, {1'b1, 21'h0ACE68});
      clr();
      step(16'hED12, 1'b1);
      step(16'hF345, 1'b0);
      step(16'hF000, 1'b0);
      chk({got.op_class, got.fast_mode}, {decoder_pkg::CLS_CALL, 1'b1});
      chk({s_pc, rpc}, {1'b1, 21'h068A24});
      $display("test two-word formats done");
   endtask : t_two
   task automatic bcase(input logic [15:0] w, input logic c, input logic [20:0] p,
         input logic t, input logic [20:0] e, input logic [10:0] o, input logic [3:0] cl);
      carry = c;
      pc = p;
      clr();
      step(w, 1'b1);
      step(16'hF000, 1'b0);
      step(16'hF000, 1'b0);
      chk({got.op_class, got.offset}, {cl, o});
      chk(got_cy, t ? 2'h2 : 2'h1);
      chk({s_pc, s_nop}, {t, t});
      if (t) chk(rpc, e);
      chk(s_fl, 1'b0);
   endtask : bcase
   task automatic t_branch();
      bcase(16'hE205, 1'b1, 21'h000100, 1'b1, 21'h00010C, 11'h005, 4'h8);
      bcase(16'hE2FB, 1'b1, 21'h000100, 1'b1, 21'h0000F8, 11'h7FB, 4'h8);
      bcase(16'hE2FB, 1'b0, 21'h000100, 1'b0, 21'h000000, 11'h7FB, 4'h8);
      bcase(16'hE280, 1'b1, 21'h000400, 1'b1, 21'h000302, 11'h780, 4'h8);
      bcase(16'hE27F, 1'b1, 21'h000400, 1'b1, 21'h000500, 11'h07F, 4'h8);
      bcase(16'hD7FF, 1'b0, 21'h000200, 1'b1, 21'h000200, 11'h7FF, 4'h7);
      $display("test relative branches done");
   endtask : t_branch

   // ====================
   // verdict, the single exit of the run
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // main sequence; inputs change on the falling edge only
   initial begin
      clk_en = 1'b1;
      rstn = 1'b0;
      word = 16'hF000;
      pc = 21'h000000;
      carry = 1'b0;
      wk = 8'h00;
      fo = 8'h00;
      bank = 4'h0;
      ext = 1'b0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      t_and();
      t_formats();
      t_two();
      t_branch();
      conclude();
   end
endmodule : tb_top

// >>> src/cpu_instruction_format_decoder.sv
// Contract
// RL1: byte ops: opcode 15:10, d 9, a 8, f
// RL2: d zero writes working register, one file
// RL3: a zero access bank, one bank select
// RL4: file move: two words, 12-bit source, destination
// RL5: lone second word executes as no-operation
// RL6: bit ops: opcode, bit position, a, f
// RL7: literal ops: opcode 15:8, immediate 7:0
// RL8: jump/call: 20-bit target over two words
// RL9: call bit 8 is the fast flag
// RL10: relative branch offsets, 11-bit and 8-bit signed
// RL11: and-with-file updates negative and zero only
// RL12: quarters: decode, read, process, write
// RL13: carry set: pc plus two plus twice offset
// RL14: carry branch two cycles taken, else one
// RL15: extended set gated by configuration bit
// RL16: one cycle; pc change or two-word adds one
// RL17: instruction cycle is four oscillator periods
//
// top of the instruction format decoder with operand execution for and-with-file
// assumes words arrive from same-clock fetch logic, one per instruction cycle
// a word is taken at the edge that ends quarter one
// a low clock enable holds every register, so fetch may stall
// the second word of a pair must follow in the next cycle
// operands valid by quarter three, pc_i through quarter four
`timescale 1ns/1ps
`include "decoder_map.svh"
module cpu_instruction_format_decoder #(
   parameter int PC_WIDTH = 21
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   // fetch side
   input wire logic [15:0] word_i,
   input wire logic [PC_WIDTH-1:0] pc_i,
   // core state
   input wire logic carry_i,
   input wire logic [7:0] working_register_i,
   input wire logic [7:0] file_operand_i,
   input wire logic [3:0] bank_select_register_i,
   input wire logic extended_set_enable_bit_i,
   // decoded results
   output decoder_pkg::decoded_t dec_o,
   output decoder_pkg::quarter_t phase_o,
   output logic [1:0] cycles_o,
   output logic nop_cycle_o,
   // operand and write-back
   output logic [11:0] read_addr_o,
   output logic read_en_o,
   output logic [7:0] result_o,
   output logic write_file_o,
   output logic write_work_o,
   output logic [1:0] flag_nz_o,
   output logic flag_we_o,
   // program counter
   output logic [PC_WIDTH-1:0] pc_load_o,
   output logic pc_load_en_o
);
   // =====================================================================
   // phase sequencing
   // sequencer phase steers the quarters; phase_q only copies it
   decoder_pkg::quarter_t phase;
   logic cycle_end;

   quarter_sequencer u_seq (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .clk_en_i(clk_en_i),
      .phase_o(phase),
      .cycle_end_o(cycle_end)
   );
   // =====================================================================
   // field decode of the incoming word
   // combinational; used only at the edge ending quarter one
   decoder_pkg::decoded_t raw_dec;

   word_field_decoder u_dec (
      .word_i(word_i),
      .extended_set_enable_bit_i(extended_set_enable_bit_i),
      .dec_o(raw_dec)
   );
   // =====================================================================
   // decode and execution state
   // decoded word, held for the whole cycle
   decoder_pkg::decoded_t cur, next_cur;

   // pairing and cycle bookkeeping
   // next word completes a two-word pair
   logic pending_second, next_pending_second;
   // spans a whole refused cycle, Q1 to Q4
   logic nop_cycle, next_nop_cycle;
   logic [1:0] cycles, next_cycles;

   // operand path: address Q2, and-result Q3
   logic [7:0] alu, next_alu;
   logic [11:0] read_addr, next_read_addr;
   logic read_en, next_read_en;

   // write-back pulses of Q4
   logic [7:0] result, next_result;
   logic write_file, next_write_file;
   logic write_work, next_write_work;
   logic [1:0] flag_nz, next_flag_nz;
   logic flag_we, next_flag_we;

   // program counter load
   logic [PC_WIDTH-1:0] pc_load, next_pc_load;
   logic pc_load_en, next_pc_load_en;
   logic [PC_WIDTH-1:0] branch_disp;
   logic [PC_WIDTH-1:0] branch_dest;

   // registered phase copy for the port
   decoder_pkg::quarter_t phase_q, next_phase_q;

   // =====================================================================
   // relative destination: incremented pc plus twice the signed offset
   // sign extend before doubling so backward branches wrap;
   // the doubled value is one bit wider, its top bit is cut on purpose
   always_comb begin
      branch_disp = PC_WIDTH'({{(PC_WIDTH-11){cur.offset[10]}}, cur.offset, 1'b0});
      branch_dest = pc_i + PC_WIDTH'(2) + branch_disp; // RL13
   end

   // =====================================================================
   // quarter walk of one instruction cycle
   // Q1 takes a word or completes a pair
   // Q2 shows the file address, Q3 forms the and
   // Q4 writes back and loads the counter
   // a taken branch adds one whole no-op cycle
   // next-state computation, one step per quarter
   // pulses default low, so each strobe lasts one enabled clock
   always_comb begin
      next_cur = cur;
      next_pending_second = pending_second;
      next_nop_cycle = nop_cycle;
      next_cycles = cycles;
      next_alu = alu;
      next_read_addr = read_addr;
      next_read_en = 1'b0;
      next_result = result;
      next_write_file = 1'b0;
      next_write_work = 1'b0;
      next_flag_nz = flag_nz;
      next_flag_we = 1'b0;
      next_pc_load = pc_load;
      next_pc_load_en = 1'b0;
      next_phase_q = phase;

      case (phase)
         decoder_pkg::Q1: begin
            // decode quarter
            if (nop_cycle) begin
               // word refused; the no-op runs on to Q4
               next_nop_cycle = 1'b1;
            end else if (pending_second) begin
               // second word: destination address or upper target bits complete the pair
               next_pending_second = 1'b0;
               if (cur.op_class == decoder_pkg::CLS_MOVE_FF) begin
                  next_read_addr = word_i[11:0]; // RL4
               end else begin
                  next_cur.target = {word_i[11:0], cur.target[7:0]}; // RL8
               end
            end else begin
               // first word; carry counts only here
               next_cur = raw_dec; // RL12
               next_pending_second = raw_dec.two_word; // RL16
               next_cycles = raw_dec.two_word ? 2'h2 : 2'h1; // RL16
               if (raw_dec.op_class == decoder_pkg::CLS_BRANCH_ALWAYS) begin
                  next_cycles = 2'h2; // pc always changes
               end else if (raw_dec.is_branch_carry) begin
                  next_cycles = carry_i ? 2'h2 : 2'h1; // RL14
               end
            end
         end

         decoder_pkg::Q2: begin
            // read quarter: file address, bank from access bank or select
            // only byte operations read; bit operations are not executed
            if (!nop_cycle && cur.op_class == decoder_pkg::CLS_BYTE) begin
               next_read_en = 1'b1; // RL12
               next_read_addr = cur.bank_from_select ?
                  {bank_select_register_i, cur.file_addr[7:0]} : // RL3
                  {(cur.file_addr[7] ? 4'hF : 4'h0), cur.file_addr[7:0]}; // RL3
            end
         end

         decoder_pkg::Q3: begin
            // process quarter
            // formed every cycle; Q4 decides whether it is used
            next_alu = working_register_i & file_operand_i; // RL11
         end

         default: begin
            // write quarter
            // the no-op ends here; ending it sooner lets the branch
            // still held in cur load the counter again
            if (nop_cycle && cycle_end) begin
               next_nop_cycle = 1'b0; // RL14
            end

            if (!nop_cycle && cur.is_and_wf && !pending_second) begin
               next_result = alu;
               next_write_file = cur.dest_is_file; // RL2
               next_write_work = !cur.dest_is_file; // RL2
               next_flag_nz = {alu[7], alu == 8'h00}; // RL11
               next_flag_we = 1'b1; // RL11
            end
            if (!nop_cycle && !pending_second) begin
               if (cur.op_class == decoder_pkg::CLS_BRANCH_ALWAYS ||
                   (cur.is_branch_carry && cycles == 2'h2)) begin
                  next_pc_load = branch_dest; // RL13
                  next_pc_load_en = 1'b1;
                  next_nop_cycle = 1'b1; // RL14
               end else if ((cur.op_class == decoder_pkg::CLS_GOTO ||
                             cur.op_class == decoder_pkg::CLS_CALL) && cycles == 2'h2) begin
                  next_pc_load = PC_WIDTH'({cur.target, 1'b0}); // RL8
                  next_pc_load_en = 1'b1;
               end
            end
         end
      endcase
   end

   // =====================================================================
   // register every value; the clock enable freezes all of it
   // reset leaves cycles at one, never an impossible count
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         // decode state and bookkeeping
         cur <= '0;
         pending_second <= 1'b0;
         nop_cycle <= 1'b0;
         cycles <= 2'h1;

         // operand path
         alu <= 8'h00;
         read_addr <= 12'h000;
         read_en <= 1'b0;

         // write-back
         result <= 8'h00;
         write_file <= 1'b0;
         write_work <= 1'b0;
         flag_nz <= 2'h0;
         flag_we <= 1'b0;

         // counter load and phase copy
         pc_load <= '0;
         pc_load_en <= 1'b0;
         phase_q <= decoder_pkg::Q1;
      end else if (clk_en_i) begin
         // a low enable holds pulses too; users qualify them
         // decode state and bookkeeping
         cur <= next_cur;
         pending_second <= next_pending_second;
         nop_cycle <= next_nop_cycle;
         cycles <= next_cycles;

         // operand path
         alu <= next_alu;
         read_addr <= next_read_addr;
         read_en <= next_read_en;

         // write-back
         result <= next_result;
         write_file <= next_write_file;
         write_work <= next_write_work;
         flag_nz <= next_flag_nz;
         flag_we <= next_flag_we;

         // counter load and phase copy
         pc_load <= next_pc_load;
         pc_load_en <= next_pc_load_en;
         phase_q <= next_phase_q;
      end
   end

   // =====================================================================
   // outputs straight from flip-flops
   // decode results
   assign dec_o = cur;
   assign phase_o = phase_q;
   assign cycles_o = cycles;
   assign nop_cycle_o = nop_cycle;
   // operand and write-back
   assign read_addr_o = read_addr;
   assign read_en_o = read_en;
   assign result_o = result;
   assign write_file_o = write_file;
   assign write_work_o = write_work;
   assign flag_nz_o = flag_nz;
   assign flag_we_o = flag_we;
   // program counter
   assign pc_load_o = pc_load;
   assign pc_load_en_o = pc_load_en;

   // =====================================================================
   // limitations
   // only and-with-file executes; other byte ops write nothing
   // extended and illegal words get a class, nothing more
   // carry counts only in quarter one
   // a pair cut by reset restarts from its first word
   // access bank: low half bank zero, high half bank F
   // branch targets wrap silently at the counter width
endmodule : cpu_instruction_format_decoder

// >>> src/decoder_map.svh
// constants for the instruction format decoder: field positions, opcodes, timing
// assumes inclusion by bare name from the design modules; the package does not include it
`ifndef DECODER_MAP_SVH
`define DECODER_MAP_SVH
// ======================================================================
// field positions
`define BYTE_OP_HI 15
`define BYTE_OP_LO 10
`define DEST_BIT 9
`define BANK_BIT 8
`define BIT_POS_HI 11
`define BIT_POS_LO 9
`define FAST_BIT 8
// ======================================================================
// opcodes
`define SECOND_WORD_TAG 4'hF
`define MOVE_FF_OP 4'hC
`define AND_WF_OP 6'h05
`define BRANCH_CARRY_OP 8'hE2
`define BRANCH_ALWAYS_OP 5'h1A
`define GOTO_OP 8'hEF
`define CALL_OP 7'h76
`define LITERAL_W_OP 8'h0E
`define BIT_SET_OP 4'h8
`define EXT_OP_HI 8'hE8
// ======================================================================
// timing
`define OSC_PER_CYCLE 4
`endif

// >>> src/decoder_pkg.sv
// types shared by the instruction format decoder
// assumes decoder_map.svh holds all numeric constants
package decoder_pkg;
   // operation class of a decoded word
   typedef enum logic [3:0] {
      CLS_NOP = 4'h0,
      CLS_BYTE = 4'h1,
      CLS_BIT = 4'h2,
      CLS_LITERAL = 4'h3,
      CLS_MOVE_FF = 4'h4,
      CLS_GOTO = 4'h5,
      CLS_CALL = 4'h6,
      CLS_BRANCH_ALWAYS = 4'h7,
      CLS_BRANCH_COND = 4'h8,
      CLS_EXTENDED = 4'h9,
      CLS_ILLEGAL = 4'hA
   } op_class_t;
   // quarter phase of an instruction cycle
   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b11,
      Q4 = 2'b10
   } quarter_t;
   // decoded fields of one instruction
   typedef struct packed {
      op_class_t op_class;
      logic [7:0] opcode;
      logic dest_is_file;
      logic bank_from_select;
      logic [2:0] bit_pos;
      logic [11:0] file_addr;
      logic [7:0] literal;
      logic [19:0] target;
      logic fast_mode;
      logic signed [10:0] offset;
      logic two_word;
      logic is_and_wf;
      logic is_branch_carry;
   } decoded_t;
endpackage : decoder_pkg

// >>> src/quarter_sequencer.sv
// four-phase sequencer producing the quarter phases of an instruction cycle
// assumes one sys_clk_i period per oscillator period
`timescale 1ns/1ps
`include "decoder_map.svh"
module quarter_sequencer (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   // phase outputs
   output decoder_pkg::quarter_t phase_o,
   output logic cycle_end_o
);
   decoder_pkg::quarter_t phase;
   decoder_pkg::quarter_t next_phase;
   // =====================================================================
   // gray walk Q1 Q2 Q3 Q4, one step per oscillator period
   always_comb begin
      case (phase)
         decoder_pkg::Q1: next_phase = decoder_pkg::Q2; // RL17
         decoder_pkg::Q2: next_phase = decoder_pkg::Q3;
         decoder_pkg::Q3: next_phase = decoder_pkg::Q4;
         default: next_phase = decoder_pkg::Q1;
      endcase
   end
   // clock enable freezes the phase
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         phase <= decoder_pkg::Q1;
      end else if (clk_en_i) begin
         phase <= next_phase;
      end
   end
   assign phase_o = phase;
   assign cycle_end_o = (phase == decoder_pkg::Q4);
endmodule : quarter_sequencer

// >>> src/word_field_decoder.sv
// combinational split of a program word into operation class and fields
// assumes the caller tracks whether the word is the second of a pair
`timescale 1ns/1ps
`include "decoder_map.svh"
module word_field_decoder (
   // inputs
   input wire logic [15:0] word_i,
   input wire logic extended_set_enable_bit_i,
   // decoded result
   output decoder_pkg::decoded_t dec_o
);
   // =====================================================================
   // class decode, most specific patterns first
   always_comb begin
      dec_o = '0;
      dec_o.op_class = decoder_pkg::CLS_ILLEGAL;
      dec_o.file_addr = {4'h0, word_i[7:0]}; // RL1
      dec_o.dest_is_file = word_i[`DEST_BIT]; // RL2
      dec_o.bank_from_select = word_i[`BANK_BIT]; // RL3
      dec_o.literal = word_i[7:0]; // RL7
      dec_o.bit_pos = word_i[`BIT_POS_HI:`BIT_POS_LO]; // RL6
      dec_o.target = {12'h000, word_i[7:0]}; // RL8
      dec_o.opcode = word_i[15:8];
      if (word_i[15:12] == `SECOND_WORD_TAG) begin
         dec_o.op_class = decoder_pkg::CLS_NOP; // RL5
      end else if (word_i[15:8] == `GOTO_OP) begin
         dec_o.op_class = decoder_pkg::CLS_GOTO;
         dec_o.two_word = 1'b1;
      end else if (word_i[15:9] == `CALL_OP) begin
         dec_o.op_class = decoder_pkg::CLS_CALL;
         dec_o.opcode = {1'b0, word_i[15:9]}; // RL9
         dec_o.fast_mode = word_i[`FAST_BIT]; // RL9
         dec_o.two_word = 1'b1;
      end else if (word_i[15:8] >= `EXT_OP_HI && word_i[15:8] != `GOTO_OP) begin
         // extended words only exist while the configuration bit is set
         dec_o.op_class = extended_set_enable_bit_i ? decoder_pkg::CLS_EXTENDED
                                                    : decoder_pkg::CLS_ILLEGAL; // RL15
      end else if (word_i[15:12] == `MOVE_FF_OP) begin
         dec_o.op_class = decoder_pkg::CLS_MOVE_FF;
         dec_o.opcode = {4'h0, word_i[15:12]}; // RL4
         dec_o.file_addr = word_i[11:0]; // RL4
         dec_o.two_word = 1'b1;
      end else if (word_i[15:11] == `BRANCH_ALWAYS_OP) begin
         dec_o.op_class = decoder_pkg::CLS_BRANCH_ALWAYS;
         dec_o.opcode = {3'h0, word_i[15:11]};
         dec_o.offset = word_i[10:0]; // RL10
      end else if (word_i[15:11] == 5'h1C) begin
         dec_o.op_class = decoder_pkg::CLS_BRANCH_COND;
         dec_o.offset = {{3{word_i[7]}}, word_i[7:0]}; // RL10
         dec_o.is_branch_carry = (word_i[15:8] == `BRANCH_CARRY_OP); // RL14
      end else if (word_i[15:8] == `LITERAL_W_OP) begin
         dec_o.op_class = decoder_pkg::CLS_LITERAL; // RL7
      end else if (word_i[15] == 1'b1 || word_i[15:12] == 4'h7) begin
         dec_o.op_class = decoder_pkg::CLS_BIT;
         dec_o.opcode = {4'h0, word_i[15:12]}; // RL6
      end else begin
         dec_o.op_class = decoder_pkg::CLS_BYTE;
         dec_o.opcode = {2'b00, word_i[`BYTE_OP_HI:`BYTE_OP_LO]}; // RL1
         dec_o.is_and_wf = (word_i[15:10] == `AND_WF_OP); // RL11
      end
   end
endmodule : word_field_decoder
